// file: actx_defines.svh
// constants for the cell slave transmit port
`ifndef ACTX_DEFINES_SVH
`define ACTX_DEFINES_SVH
`define ACTX_BYTE_W        8
`define ACTX_ADDR_W        5
`define ACTX_CELL_LEN      53
`define ACTX_CNT_W         6
`define ACTX_FIFO_DEPTH    8
`define ACTX_FIFO_AW       3
`define ACTX_OWN_ADDR      5'h01
`define ACTX_NULL_ADDR     5'h1F
`define ACTX_BYTE_RESET    8'h00
`endif

// file: actx_fifo.sv
// byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "actx_defines.svh"
module actx_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [AW:0]      count_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign count_out    = count;
  assign rd_data_out  = mem[rd_ptr];

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
endmodule : actx_fifo

// file: actx_master_model.sv
// behavioural master controller on the far side of the transmit link
`timescale 1ns/1ps
module actx_master_model
(
  input  wire logic       run_in,
  input  wire logic       pull_in,
  input  wire logic       force_in,
  input  wire logic [4:0] addr_in,
  input  wire logic       clav_in,
  input  wire logic       clav_oe_in,
  input  wire logic       bus_oe_in,
  output logic            link_clk_out,
  output logic            enable_n_out,
  output logic      [4:0] addr_out
);
  logic want;
  int   cnt;
  // ==========================================================
  // link clock, still between frames, phase unrelated to sys clock
  initial
  begin
    link_clk_out = 1'b0;
    #3.3;
    forever
    begin
      wait (run_in);
      #80 link_clk_out = 1'b1;
      #80 link_clk_out = 1'b0;
    end
  end
  assign addr_out = addr_in;
  // ==========================================================
  // decide at the rise, drive at the fall so the port sees it next rise
  initial
  begin
    want = 1'b0;
    cnt = 0;
    enable_n_out = 1'b1;
  end
  always @(posedge link_clk_out)
  begin
    if (bus_oe_in)
      cnt = (cnt == 52) ? 0 : cnt + 1;
    if (want && !pull_in && (cnt == 0 || !bus_oe_in))
      want = 1'b0;
    else if (!want && pull_in && clav_oe_in && clav_in)
      want = 1'b1;
  end
  // forcing breaks the polling rule on purpose for refusal checks
  always @(negedge link_clk_out)
    enable_n_out <= !(want || force_in);
endmodule : actx_master_model

// file: actx_pkg.sv
// types for the cell slave transmit port
package actx_pkg;
  typedef enum logic [1:0]
  {
    ACTX_IDLE = 2'b00,
    ACTX_SEND = 2'b01
  } actx_state_t;
endpackage : actx_pkg

// file: actx_port.sv
// cell slave transmit port, device end
// Summary of operation
// R01: the master supplies the transmit cell clock and all link activity follows its edges.
// R02: with the port select at 0 the clock, available, enable, start and address bit 0 are tied off.
// R03: cell available is 1 when a complete cell is ready to send and 0 otherwise; here it rises once the first 8 bytes of a cell are buffered.
// R04: after the master asserts transfer enable the first byte and start of cell appear in the next cycle.
// R05: start of cell is launched on a rising link clock edge with the first byte on the bus.
// R06: the master drives a five bit slave address selecting one of up to 31 slaves.
// R07: with port select at 1 the shared pins act as address inputs, otherwise serial port pins.
// R08: cell bytes leave on the eight bit bus, each launched on a rising link clock edge.
// R09: the port answers enable and reports availability only while the address matches its own; once a cell has started, enable is answered whatever the address.
`timescale 1ns/1ps
`include "actx_defines.svh"
module actx_port
  import actx_pkg::*;
(
  input  wire logic                     CLK_SYS_IN,
  input  wire logic                     RST_IN,
  input  wire logic                     CELL_PORT_SELECT_IN,
  input  wire logic                     TX_CELL_CLOCK_IN,
  input  wire logic                     TX_TRANSFER_ENABLE_N_IN,
  input  wire logic [`ACTX_ADDR_W-1:0]  TX_SLAVE_ADDRESS_IN,
  output logic                          TX_CELL_AVAILABLE_OUT,
  output logic                          TX_CELL_AVAILABLE_OE_OUT,
  output logic                          TX_START_OF_CELL_OUT,
  output logic                          TX_START_OF_CELL_OE_OUT,
  output logic      [`ACTX_BYTE_W-1:0]  TX_CELL_BYTE_BUS_OUT,
  output logic                          TX_CELL_BYTE_BUS_OE_OUT,
  input  wire logic [`ACTX_BYTE_W-1:0]  CELL_BYTE_IN,
  input  wire logic                     CELL_VALID_IN,
  output logic                          CELL_READY_OUT
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  // the link clock is just sampled; at 160 ns it gives 40 sys cycles
  logic       clk_meta;
  logic       clk_sync;
  logic       ena_meta;
  logic       ena_sync;
  logic       sel_meta;
  logic       sel_sync;
  logic [`ACTX_ADDR_W-1:0] adr_meta;
  logic [`ACTX_ADDR_W-1:0] adr_sync;
  logic       clk_prev;
  logic       link_rise;
  logic       sel_addr_ok;
  logic [`ACTX_ADDR_W-1:0] eff_addr;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      clk_meta <= '0;
      clk_sync <= '0;
      ena_meta <= 1'b1;
      ena_sync <= 1'b1;
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      adr_meta <= `ACTX_NULL_ADDR;
      adr_sync <= `ACTX_NULL_ADDR;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_meta <= TX_CELL_CLOCK_IN;
      clk_sync <= clk_meta;
      ena_meta <= TX_TRANSFER_ENABLE_N_IN;
      ena_sync <= ena_meta;
      sel_meta <= CELL_PORT_SELECT_IN;
      sel_sync <= sel_meta;
      adr_meta <= TX_SLAVE_ADDRESS_IN;
      adr_sync <= adr_meta;
      clk_prev <= clk_sync;
    end
  end

  // deselected: link clock treated as stopped, address bit 0 forced low
  assign link_rise   = sel_sync && clk_sync && !clk_prev; // see R01 see R02
  assign eff_addr    = sel_sync ? adr_sync
                                : {adr_sync[`ACTX_ADDR_W-1:1], 1'b0}; // see R07
  assign sel_addr_ok = sel_sync && (eff_addr == `ACTX_OWN_ADDR); // see R09

  // ==========================================================
  // cell buffer
  // ==========================================================
  logic [`ACTX_BYTE_W-1:0]  fifo_data;
  logic                     fifo_valid;
  logic                     fifo_pop;
  logic [`ACTX_FIFO_AW:0]   fifo_count;
  logic [`ACTX_CNT_W-1:0]   in_cnt;
  logic [`ACTX_CNT_W-1:0]   next_in_cnt;
  logic [1:0]               cells_ready;
  logic [1:0]               next_cells_ready;
  logic                     push_ok;

  actx_fifo
  #(
    .WIDTH (`ACTX_BYTE_W),
    .DEPTH (`ACTX_FIFO_DEPTH),
    .AW    (`ACTX_FIFO_AW)
  )
  u_fifo
  (
    .clk_in       (CLK_SYS_IN),
    .rst_in       (RST_IN),
    .wr_data_in   (CELL_BYTE_IN),
    .wr_valid_in  (CELL_VALID_IN),
    .wr_ready_out (CELL_READY_OUT),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop),
    .count_out    (fifo_count)
  );

  // ==========================================================
  // transmit state machine
  // ==========================================================
  actx_state_t             state;
  actx_state_t             next_state;
  logic [`ACTX_CNT_W-1:0]  out_cnt;
  logic [`ACTX_CNT_W-1:0]  next_out_cnt;
  logic                    soc;
  logic                    next_soc;
  logic [`ACTX_BYTE_W-1:0] dbyte;
  logic [`ACTX_BYTE_W-1:0] next_dbyte;
  logic                    clav;
  logic                    next_clav;
  logic                    drive;
  logic                    next_drive;
  logic                    cell_done;
  logic                    cell_armed;

  // the buffer is shorter than a cell, so a cell is offered once its
  // first buffer-full of bytes is in; the source must then keep pace
  // with the link, a limitation accepted to keep the buffer small
  assign push_ok   = CELL_VALID_IN && CELL_READY_OUT;
  assign cell_done = push_ok && (in_cnt == 6'(`ACTX_CELL_LEN - 1));
  assign cell_armed = push_ok && (in_cnt == 6'(`ACTX_FIFO_DEPTH - 1));
  // the first byte leaves the buffer at launch, like every later one
  assign fifo_pop  = link_rise && !ena_sync && fifo_valid
                     && (state == ACTX_SEND
                         || (sel_addr_ok && cells_ready != 2'b00));

  always_comb
  begin
    next_in_cnt      = in_cnt;
    next_cells_ready = cells_ready;
    next_state       = state;
    next_out_cnt     = out_cnt;
    next_soc         = soc;
    next_dbyte       = dbyte;
    next_clav        = clav;
    next_drive       = drive;
    if (push_ok)
    begin
      next_in_cnt = cell_done ? '0 : in_cnt + 6'(1);
    end
    if (link_rise)
    begin
      next_soc  = 1'b0;
      next_clav = sel_addr_ok && (cells_ready != 2'b00); // see R03 see R09
      unique case (state)
        ACTX_IDLE:
        begin
          next_drive = 1'b0;
          if (!ena_sync && sel_addr_ok && cells_ready != 2'b00 && fifo_valid)
          begin
            next_state   = ACTX_SEND;
            next_soc     = 1'b1; // see R04 see R05
            next_dbyte   = fifo_data; // see R08
            next_drive   = 1'b1;
            next_out_cnt = 6'(1);
            next_cells_ready = cells_ready - 2'b01;
          end
        end
        ACTX_SEND:
        begin
          if (!ena_sync && fifo_valid)
          begin
            next_dbyte   = fifo_data; // see R08
            next_out_cnt = out_cnt + 6'(1);
            if (out_cnt == 6'(`ACTX_CELL_LEN - 1))
            begin
              next_state = ACTX_IDLE;
            end
          end
        end
      endcase
    end
    if (cell_armed && next_cells_ready != 2'b11) // see R03
    begin
      next_cells_ready = next_cells_ready + 2'b01;
    end
    if (!sel_sync)
    begin
      next_clav  = 1'b0; // see R02
      next_soc   = 1'b0;
      next_drive = 1'b0;
      next_dbyte = `ACTX_BYTE_RESET; // see R02
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      in_cnt      <= '0;
      cells_ready <= 2'b00;
      state       <= ACTX_IDLE;
      out_cnt     <= '0;
      soc         <= 1'b0;
      dbyte       <= `ACTX_BYTE_RESET;
      clav        <= 1'b0;
      drive       <= 1'b0;
    end
    else
    begin
      in_cnt      <= next_in_cnt;
      cells_ready <= next_cells_ready;
      state       <= next_state;
      out_cnt     <= next_out_cnt;
      soc         <= next_soc;
      dbyte       <= next_dbyte;
      clav        <= next_clav;
      drive       <= next_drive;
    end
  end

  assign TX_CELL_AVAILABLE_OUT    = clav;
  assign TX_CELL_AVAILABLE_OE_OUT = sel_addr_ok; // see R02
  assign TX_START_OF_CELL_OUT     = soc;
  assign TX_START_OF_CELL_OE_OUT  = drive;
  assign TX_CELL_BYTE_BUS_OUT     = dbyte;
  assign TX_CELL_BYTE_BUS_OE_OUT  = drive;

  // ==========================================================
  // checks
  // ==========================================================
  property p_soc_pulse;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    $rose(soc) |-> $past(link_rise) && $past(state) == ACTX_IDLE;
  endproperty
  a_soc_pulse: assert property (p_soc_pulse) // see R05
    else $error("start of cell not on link edge");

  property p_soc_drive;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    soc |-> drive && state == ACTX_SEND;
  endproperty
  a_soc_drive: assert property (p_soc_drive) // see R04
    else $error("start of cell without bus drive");

  property p_desel_off;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    !sel_sync ##1 !sel_sync |-> !clav && !drive && !TX_CELL_AVAILABLE_OE_OUT;
  endproperty
  a_desel_off: assert property (p_desel_off) // see R02
    else $error("pins active while deselected");

  property p_clav_addr;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    $rose(clav) |-> $past(sel_addr_ok) && $past(cells_ready) != 2'b00;
  endproperty
  a_clav_addr: assert property (p_clav_addr) // see R03
    else $error("available raised without cell or address");

  property p_no_cell;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    link_rise && cells_ready == 2'b00 && !cell_done |=> !clav;
  endproperty
  a_no_cell: assert property (p_no_cell) // see R03
    else $error("available while no cell ready");

  property p_oe_addr;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    TX_CELL_AVAILABLE_OE_OUT |-> $past(TX_SLAVE_ADDRESS_IN, 2) == `ACTX_OWN_ADDR;
  endproperty
  a_oe_addr: assert property (p_oe_addr) // see R09
    else $error("available driven for another address");

  property p_byte_edge;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    dbyte != $past(dbyte) |-> $past(link_rise) || !$past(sel_sync);
  endproperty
  a_byte_edge: assert property (p_byte_edge) // see R08
    else $error("byte changed off link edge");

  property p_addr_map;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
    sel_sync |-> eff_addr == adr_sync;
  endproperty
  a_addr_map: assert property (p_addr_map) // see R07
    else $error("address pins not used while selected");

  c_cell_start: cover property (@(posedge CLK_SYS_IN) $rose(soc));
  c_cell_end: cover property (@(posedge CLK_SYS_IN)
    state == ACTX_SEND ##1 state == ACTX_IDLE);
  c_clav: cover property (@(posedge CLK_SYS_IN) $rose(clav));
endmodule : actx_port

// file: atm_cell_slave_tx_port_test.sv
// self-checking bench for the cell slave transmit port
`timescale 1ns/1ps
`include "actx_defines.svh"
module atm_cell_slave_tx_port_test;
  logic       clk, rst, sel, valid, ready, run, pull, frc;
  logic       link, en_n, clav, clav_oe, soc, soc_oe, bus_oe;
  logic [4:0] addr_req, addr;
  logic [7:0] din, bus;
  logic [8:0] notes[$];
  int         errors, n_tests, cyc, k;

  actx_port dut_u (.CLK_SYS_IN(clk), .RST_IN(rst),
    .CELL_PORT_SELECT_IN(sel), .TX_CELL_CLOCK_IN(link),
    .TX_TRANSFER_ENABLE_N_IN(en_n), .TX_SLAVE_ADDRESS_IN(addr),
    .TX_CELL_AVAILABLE_OUT(clav), .TX_CELL_AVAILABLE_OE_OUT(clav_oe),
    .TX_START_OF_CELL_OUT(soc), .TX_START_OF_CELL_OE_OUT(soc_oe),
    .TX_CELL_BYTE_BUS_OUT(bus), .TX_CELL_BYTE_BUS_OE_OUT(bus_oe),
    .CELL_BYTE_IN(din), .CELL_VALID_IN(valid), .CELL_READY_OUT(ready));

  actx_master_model master_u (.run_in(run), .pull_in(pull),
    .force_in(frc), .addr_in(addr_req), .clav_in(clav),
    .clav_oe_in(clav_oe), .bus_oe_in(bus_oe), .link_clk_out(link),
    .enable_n_out(en_n), .addr_out(addr));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [8:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ready is read at the falling edge, so it tells whether the next rise takes
  task automatic push(input int idx, input logic [7:0] b);
    int w;
    w = 0;
    din = b;
    valid = 1'b1;
    #1;
    while (ready !== 1'b1 && w < 20000)
    begin
      @(negedge clk);
      #1;
      w++;
    end
    notes.push_back({1'(idx % `ACTX_CELL_LEN == 0), b});
    @(negedge clk);
  endtask : push
  // ==========================================================
  // watcher: every byte seen on the link takes the oldest note, or is flagged as a spare byte when no note is left
  always @(posedge link)
    if (bus_oe === 1'b1)
    begin
      check("soc drive", {8'h00, soc_oe}, 9'h001);
      if (notes.size() == 0)
        check("spare byte", {8'h00, bus_oe}, 9'h000);
      else
        check("cell byte", {soc, bus}, notes.pop_front());
    end
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    sel = 1'b1;
    valid = 1'b0;
    din = 8'h00;
    run = 1'b0;
    pull = 1'b0;
    frc = 1'b0;
    addr_req = `ACTX_OWN_ADDR;
    void'($urandom(32'h65af2972));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    repeat (4) @(posedge link);
    @(negedge clk);
    check("idle clav", {7'h00, clav_oe, clav}, 9'h002);
    run = 1'b0;
    for (k = 0; k < `ACTX_FIFO_DEPTH; k++)
      push(k, 8'($urandom));
    din = 8'($urandom);
    repeat (16) @(negedge clk);
    check("full ready", {8'h00, ready}, 9'h000);
    run = 1'b1;
    pull = 1'b1;
    // two cells back to back while the master pops
    for (k = `ACTX_FIFO_DEPTH; k < 2 * `ACTX_CELL_LEN; k++)
      push(k, (k == `ACTX_FIFO_DEPTH) ? din : 8'($urandom));
    valid = 1'b0;
    k = 0;
    while (notes.size() > 0 && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    check("drained", 9'(notes.size()), 9'h000);
    pull = 1'b0;
    repeat (3) @(posedge link);
    @(negedge clk);
    check("no cell", {6'h00, clav_oe, clav, bus_oe}, 9'h004);
    addr_req = `ACTX_OWN_ADDR + 5'h01;
    frc = 1'b1;
    repeat (6) @(posedge link);
    @(negedge clk);
    check("foreign addr", {6'h00, clav_oe, soc_oe, bus_oe}, 9'h000);
    addr_req = `ACTX_OWN_ADDR;
    sel = 1'b0;
    repeat (6) @(posedge link);
    @(negedge clk);
    check("off oe", {5'h00, clav_oe, soc_oe, bus_oe, clav}, 9'h000);
    check("off bus", {soc, bus}, 9'h000);
    frc = 1'b0;
    run = 1'b0;
    report_and_stop();
  end
endmodule : atm_cell_slave_tx_port_test
